// *** logic/origin_search_config_logic.sv ***
// Origin search controller for one pulse output channel with APB registers
//
// Overview of operation
// [R1] Pattern 1: origin accepted once proximity input has turned active.
// [R2] Pattern 2: origin accepted at once, proximity input ignored.
// [R3] Without proximity input only initial and proximity speeds are used; pulses here run at proximity speed alone.
// [R4] Limit mode 0: limit in travel direction reverses the direction.
// [R5] Limit mode 1: limit stops pulses and raises an error.
// [R6] Drive type 0 stepper, 1 servo, 2 servo with positioning done input.
// [R7] Type 0 drives no counter reset and ignores positioning done.
// [R8] Positioning done input watched only in drive type 2.
// [R9] Origin input polarity normally open or normally closed by setting.
// [R10] Proximity input polarity set by its own separate setting.
// [R11] High speed target in pps, limited to 0 to 100 kpps.
// [R12] Search refused unless high above proximity above initial speed.
// [R13] Origin found on rising edge of origin while moving in search direction.
// [R14] Pattern 0: origin accepted after proximity went active then inactive.
// [R15] Polarity applied to origin and proximity before edge or level checks.
`timescale 1ns/1ps
module origin_search_config_logic (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Sensors and drive feedback, asynchronous pins
  input wire origin_search_pkg::sensor_t sensors,
  // Pulse and drive outputs
  output logic forward_rotation,
  output logic reverse_rotation,
  output logic err_counter_reset,
  output logic search_busy,
  // Interrupt
  output logic irq
);
  import origin_search_pkg::*;

  typedef struct packed {
    config_t cfg;
    logic [SPEED_W-1:0] init_spd;
    logic [SPEED_W-1:0] prox_spd;
    logic [SPEED_W-1:0] high_spd;
    evt_t irq_st;
    evt_t irq_mask;
    logic [31:0] rdata;
    logic slverr;
    sensor_t sync1;
    sensor_t sync2;
    logic origin_prev;
    search_st_t st;
    logic travel_fwd;
    logic armed;
    logic prox_seen;
    logic found;
    logic [ECR_CNT_W-1:0] ecr_cnt;
    logic ecr;
    logic fwd_out;
    logic rev_out;
  } regs_t;

  // Count seen on the edge that drops the pulse, so the pulse lasts ECR_CYCLES
  localparam logic [ECR_CNT_W-1:0] ECR_LAST = ECR_CNT_W'(ECR_CYCLES);

  regs_t r_q, r_d;
  logic step;
  logic [SPEED_W-1:0] run_rate;

  // ---------------------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------------------
  // Clamp a written speed into the legal range
  function automatic logic [SPEED_W-1:0] clamp_speed(input logic [31:0] val);
    if (val > 32'(MAX_PPS)) begin
      return MAX_PPS; // R11
    end
    return val[SPEED_W-1:0];
  endfunction : clamp_speed

  // A two-bit field written as the illegal code keeps its old value
  function automatic logic [1:0] pick_field(input logic [1:0] new_val, input logic [1:0] old_val);
    return (new_val == FIELD_ILLEGAL) ? old_val : new_val;
  endfunction : pick_field

  // Known register offsets
  function automatic logic is_mapped(input logic [7:0] addr);
    return addr inside {OFS_CONFIG, OFS_INIT_SPEED, OFS_PROX_SPEED, OFS_HIGH_SPEED,
                        OFS_COMMAND, OFS_STATUS, OFS_IRQ_STATUS, OFS_IRQ_MASK};
  endfunction : is_mapped

  // ---------------------------------------------------------------------------
  // Step rate generator
  // ---------------------------------------------------------------------------
  // High speed only in the fast phase, proximity speed otherwise
  assign run_rate = (r_q.st == ST_FAST) ? r_q.high_spd : r_q.prox_spd;

  pulse_rate_gen #(
    .RATE_W(SPEED_W)
  ) u_rate (
    .pclk(pclk),
    .presetn(presetn),
    .run(r_q.st inside {ST_FAST, ST_SLOW}),
    .rate_pps(run_rate),
    .step(step)
  );

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    logic origin_act;
    logic prox_act;
    logic origin_rise;
    logic limit_hit;
    logic wr;
    logic start;
    logic abort;
    logic speeds_ok;
    logic done_in;
    config_t wcfg;
    evt_t set;
    evt_t clr;
    origin_act = 1'b0;
    prox_act = 1'b0;
    origin_rise = 1'b0;
    limit_hit = 1'b0;
    wr = 1'b0;
    start = 1'b0;
    abort = 1'b0;
    speeds_ok = 1'b0;
    done_in = 1'b0;
    wcfg = config_t'(pwdata[CONFIG_W-1:0]);
    set = '0;
    clr = '0;
    r_d = r_q;

    // Two-stage synchronisers on the pins
    r_d.sync1 = sensors;
    r_d.sync2 = r_q.sync1;

    // Polarity first, then edge and level qualification
    origin_act = r_q.sync2.origin ^ r_q.cfg.origin_nc; // R9 R15
    prox_act = r_q.sync2.prox ^ r_q.cfg.prox_nc; // R10 R15
    r_d.origin_prev = origin_act;
    origin_rise = origin_act & ~r_q.origin_prev;
    limit_hit = r_q.travel_fwd ? r_q.sync2.limit_fwd : r_q.sync2.limit_rev;
    done_in = r_q.sync2.positioning_done_input;

    // APB write decode at the access phase
    wr = psel & penable & pwrite;
    if (wr) begin
      unique case (paddr)
        OFS_CONFIG: begin
          r_d.cfg = wcfg;
          r_d.cfg.prox_pattern = pick_field(wcfg.prox_pattern, r_q.cfg.prox_pattern);
          r_d.cfg.drive_type = pick_field(wcfg.drive_type, r_q.cfg.drive_type); // R6
        end
        OFS_INIT_SPEED: r_d.init_spd = clamp_speed(pwdata);
        OFS_PROX_SPEED: r_d.prox_spd = clamp_speed(pwdata);
        OFS_HIGH_SPEED: r_d.high_spd = clamp_speed(pwdata); // R11
        OFS_COMMAND: begin
          start = pwdata[CMD_START_BIT];
          abort = pwdata[CMD_ABORT_BIT];
        end
        OFS_IRQ_STATUS: clr = evt_t'(pwdata[EVT_W-1:0]);
        OFS_IRQ_MASK: r_d.irq_mask = evt_t'(pwdata[EVT_W-1:0]);
        default: ;
      endcase
    end

    // Registered read data and error, captured in the setup phase
    if (psel & ~penable) begin
      r_d.slverr = ~is_mapped(paddr);
      unique case (paddr)
        OFS_CONFIG: r_d.rdata = 32'(r_q.cfg);
        OFS_INIT_SPEED: r_d.rdata = 32'(r_q.init_spd);
        OFS_PROX_SPEED: r_d.rdata = 32'(r_q.prox_spd);
        OFS_HIGH_SPEED: r_d.rdata = 32'(r_q.high_spd);
        OFS_STATUS: r_d.rdata = {19'h00000, r_q.st, 3'h0, r_q.found, r_q.armed,
                                 r_q.travel_fwd, r_q.ecr, r_q.st != ST_IDLE};
        OFS_IRQ_STATUS: r_d.rdata = 32'(r_q.irq_st);
        OFS_IRQ_MASK: r_d.rdata = 32'(r_q.irq_mask);
        default: r_d.rdata = 32'h00000000;
      endcase
    end

    // Speed ordering check
    speeds_ok = (r_q.high_spd > r_q.prox_spd) && (r_q.prox_spd > r_q.init_spd);

    // Direction pulse outputs follow each generated step
    r_d.fwd_out = step & r_q.travel_fwd;
    r_d.rev_out = step & ~r_q.travel_fwd;
    r_d.ecr = 1'b0;

    // Search sequencer
    unique case (r_q.st)
      ST_IDLE: begin
        if (start) begin
          if (!speeds_ok) begin
            set.refused = 1'b1; // R12
          end else begin
            r_d.travel_fwd = ~r_q.cfg.search_reverse;
            r_d.found = 1'b0;
            r_d.prox_seen = 1'b0;
            if (r_q.cfg.prox_pattern == PROX_UNUSED) begin
              r_d.st = ST_SLOW; // R3
              r_d.armed = 1'b1; // R2
            end else begin
              r_d.st = ST_FAST;
              r_d.armed = 1'b0;
            end
          end
        end
      end
      ST_FAST: begin
        if (prox_act) begin
          r_d.st = ST_SLOW;
          r_d.prox_seen = 1'b1;
          r_d.armed = (r_q.cfg.prox_pattern == PROX_ON); // R1
        end
      end
      ST_SLOW: begin
        if (r_q.cfg.prox_pattern == PROX_ON_OFF && r_q.prox_seen && !prox_act) begin
          r_d.armed = 1'b1; // R14
        end
        if (r_q.armed && origin_rise && (r_q.travel_fwd == ~r_q.cfg.search_reverse)) begin
          r_d.found = 1'b1; // R13
          r_d.armed = 1'b0;
          if (r_q.cfg.drive_type == DRIVE_STEPPER) begin
            r_d.st = ST_IDLE; // R7
            set.done = 1'b1;
          end else begin
            r_d.st = ST_ECR;
            r_d.ecr_cnt = '0;
          end
        end
      end
      ST_ECR: begin
        r_d.ecr = 1'b1; // R7
        r_d.ecr_cnt = r_q.ecr_cnt + ECR_CNT_W'(1);
        if (r_q.ecr_cnt == ECR_LAST) begin
          r_d.ecr = 1'b0;
          if (r_q.cfg.drive_type == DRIVE_SERVO_DONE) begin
            r_d.st = ST_WAIT_DONE; // R8
          end else begin
            r_d.st = ST_IDLE;
            set.done = 1'b1;
          end
        end
      end
      ST_WAIT_DONE: begin
        if (done_in) begin
          r_d.st = ST_IDLE; // R8
          set.done = 1'b1;
        end
      end
      default: r_d.st = ST_IDLE;
    endcase

    // Limit handling while pulses are being issued
    if ((r_q.st inside {ST_FAST, ST_SLOW}) && limit_hit) begin
      if (r_q.cfg.limit_mode == LIMIT_REVERSE) begin
        r_d.travel_fwd = ~r_q.travel_fwd; // R4
        set.reversed = 1'b1;
      end else begin
        r_d.st = ST_IDLE; // R5
        r_d.armed = 1'b0;
        set.limit_err = 1'b1; // R5
      end
    end

    // Software abort stops any search without an event
    if (abort && r_q.st != ST_IDLE) begin
      r_d.st = ST_IDLE;
      r_d.armed = 1'b0;
      r_d.ecr = 1'b0;
    end

    // Sticky events, a new event wins over a clear
    r_d.irq_st = (r_q.irq_st & ~clr) | set;
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_q <= '0;
      r_q.cfg <= config_t'(CONFIG_RESET);
      r_q.init_spd <= INIT_SPEED_RESET;
      r_q.prox_spd <= PROX_SPEED_RESET;
      r_q.high_spd <= HIGH_SPEED_RESET;
      r_q.st <= ST_IDLE;
      r_q.travel_fwd <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  // Zero wait state answer, data captured during setup
  assign pready = 1'b1;
  assign prdata = r_q.rdata;
  assign pslverr = r_q.slverr & psel & penable;
  assign forward_rotation = r_q.fwd_out;
  assign reverse_rotation = r_q.rev_out;
  assign err_counter_reset = r_q.ecr;
  assign search_busy = (r_q.st != ST_IDLE);
  assign irq = |(r_q.irq_st & r_q.irq_mask);

endmodule : origin_search_config_logic

// *** logic/origin_search_pkg.sv ***
// Shared constants, register map and carrier types for the origin search channel
package origin_search_pkg;

  // ---------------------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------------------
  localparam int CLK_HZ = 25_000_000;
  localparam int ACC_W = 26;
  localparam int ECR_TIME_NS = 10_000;
  // Error counter reset pulse length, least time so rounded up
  localparam int ECR_CYCLES = (ECR_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int ECR_CNT_W = 9;

  // ---------------------------------------------------------------------------
  // Speed settings
  // ---------------------------------------------------------------------------
  localparam int SPEED_W = 17;
  localparam logic [SPEED_W-1:0] MAX_PPS = 17'h186a0;

  // ---------------------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_INIT_SPEED = 8'h04;
  localparam logic [7:0] OFS_PROX_SPEED = 8'h08;
  localparam logic [7:0] OFS_HIGH_SPEED = 8'h0c;
  localparam logic [7:0] OFS_COMMAND = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h1c;

  // ---------------------------------------------------------------------------
  // Field positions and encodings
  // ---------------------------------------------------------------------------
  localparam int CMD_START_BIT = 0;
  localparam int CMD_ABORT_BIT = 1;
  localparam int CONFIG_W = 8;
  localparam int EVT_W = 4;
  localparam logic [1:0] PROX_ON_OFF = 2'h0;
  localparam logic [1:0] PROX_ON = 2'h1;
  localparam logic [1:0] PROX_UNUSED = 2'h2;
  localparam logic LIMIT_REVERSE = 1'h0;
  localparam logic LIMIT_STOP_ERR = 1'h1;
  localparam logic [1:0] DRIVE_STEPPER = 2'h0;
  localparam logic [1:0] DRIVE_SERVO = 2'h1;
  localparam logic [1:0] DRIVE_SERVO_DONE = 2'h2;
  localparam logic [1:0] FIELD_ILLEGAL = 2'h3;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [CONFIG_W-1:0] CONFIG_RESET = 8'h00;
  localparam logic [SPEED_W-1:0] INIT_SPEED_RESET = 17'h00064;
  localparam logic [SPEED_W-1:0] PROX_SPEED_RESET = 17'h003e8;
  localparam logic [SPEED_W-1:0] HIGH_SPEED_RESET = 17'h02710;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  // Configuration word, bit 7 down to bit 0
  typedef struct packed {
    logic prox_nc;
    logic origin_nc;
    logic [1:0] drive_type;
    logic limit_mode;
    logic [1:0] prox_pattern;
    logic search_reverse;
  } config_t;

  // Sensor and drive inputs
  typedef struct packed {
    logic limit_rev;
    logic limit_fwd;
    logic positioning_done_input;
    logic prox;
    logic origin;
  } sensor_t;

  // Sticky events, bit 3 down to bit 0
  typedef struct packed {
    logic reversed;
    logic refused;
    logic limit_err;
    logic done;
  } evt_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_FAST = 5'b00010,
    ST_SLOW = 5'b00100,
    ST_ECR = 5'b01000,
    ST_WAIT_DONE = 5'b10000
  } search_st_t;

endpackage : origin_search_pkg

// *** logic/pulse_rate_gen.sv ***
// Phase accumulator that emits one-cycle steps at a rate given in pulses per second
`timescale 1ns/1ps
module pulse_rate_gen #(
  parameter int RATE_W = origin_search_pkg::SPEED_W
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Rate control
  input wire logic run,
  input wire logic [RATE_W-1:0] rate_pps,
  // Step output
  output logic step
);
  import origin_search_pkg::*;

  typedef struct packed {
    logic [ACC_W-1:0] acc;
    logic step;
  } gen_t;

  localparam logic [ACC_W-1:0] CLK_HZ_W = ACC_W'(CLK_HZ);

  gen_t r_q, r_d;

  // Add the rate every cycle while run is high, clear otherwise, wrap at the clock rate
  always_comb begin
    logic [ACC_W-1:0] sum;
    sum = '0;
    r_d = r_q;
    r_d.step = 1'b0;
    if (!run) begin
      r_d.acc = '0;
    end else begin
      sum = r_q.acc + ACC_W'(rate_pps);
      if (sum >= CLK_HZ_W) begin
        r_d.acc = sum - CLK_HZ_W;
        r_d.step = 1'b1;
      end else begin
        r_d.acc = sum;
      end
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign step = r_q.step;

endmodule : pulse_rate_gen

// *** tb/origin_search_checker.sv ***
// Port assertions for the origin search controller
`timescale 1ns/1ps
module origin_search_checker
  import origin_search_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // Drive outputs
  input wire logic forward_rotation,
  input wire logic reverse_rotation,
  input wire logic err_counter_reset,
  input wire logic search_busy
);
  logic [8:0] ecr_len_q;

  // Length of the current counter reset pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ecr_len_q <= 9'h000;
    end else begin
      ecr_len_q <= err_counter_reset ? ecr_len_q + 9'h001 : 9'h000;
    end
  end

  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence fwd_step_s; $rose(forward_rotation); endsequence
  sequence rev_step_s; $rose(reverse_rotation); endsequence
  sequence ecr_end_s; $fell(err_counter_reset); endsequence

  pready_high_a: assert property (pready) else $error("pready low");
  err_access_a: assert property (pslverr |-> psel && penable) else $error("pslverr outside access");
  unmapped_err_a: assert property (psel && penable && paddr > OFS_IRQ_MASK |-> pslverr)
    else $error("unmapped access without error");
  fwd_single_a: assert property (fwd_step_s |=> !forward_rotation [*8]) else $error("forward step too long");
  rev_single_a: assert property (rev_step_s |=> !reverse_rotation [*8]) else $error("reverse step too long");
  dir_excl_a: assert property (!(forward_rotation && reverse_rotation)) else $error("both directions");
  ecr_len_a: assert property (ecr_end_s |-> ecr_len_q == ECR_CYCLES) else $error("counter reset length");
  ecr_quiet_a: assert property (err_counter_reset |-> search_busy && !forward_rotation && !reverse_rotation)
    else $error("pulses during counter reset");
  idle_quiet_a: assert property (!search_busy && !$past(search_busy) |-> !forward_rotation && !reverse_rotation)
    else $error("pulses while idle");
endmodule : origin_search_checker

bind origin_search_config_logic origin_search_checker chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
  .pslverr(pslverr), .forward_rotation(forward_rotation), .reverse_rotation(reverse_rotation),
  .err_counter_reset(err_counter_reset), .search_busy(search_busy)
);

// *** tb/motor_side_model.sv ***
// Motor drive with origin, proximity and limit sensors on a step axis
`timescale 1ns/1ps
module motor_side_model
  import origin_search_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Step and drive control
  input wire logic forward_rotation,
  input wire logic reverse_rotation,
  input wire logic err_counter_reset,
  // Bench control
  input wire logic rezero,
  input wire logic origin_nc,
  input wire logic prox_nc,
  // Sensor pins and axis position
  output sensor_t sensors,
  output logic signed [15:0] pos
);
  logic [7:0] done_cnt;
  logic ecr_q;

  // Axis position and settle time after the counter reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn || rezero) begin
      pos <= 16'sh0000;
      done_cnt <= 8'h00;
      ecr_q <= 1'b0;
    end else begin
      pos <= pos + 16'(forward_rotation) - 16'(reverse_rotation);
      ecr_q <= err_counter_reset;
      if (ecr_q && !err_counter_reset) begin
        done_cnt <= 8'h01;
      end else if (done_cnt != 8'h00 && done_cnt < 8'd100) begin
        done_cnt <= done_cnt + 8'h01;
      end
    end
  end

  // Origin marks at 1, 4, 7; proximity over 3 to 5; limits at 10 and -3
  assign sensors.origin = (pos == 1 || pos == 4 || pos == 7) ^ origin_nc;
  assign sensors.prox = (pos >= 3 && pos <= 5) ^ prox_nc;
  assign sensors.limit_fwd = pos >= 10;
  assign sensors.limit_rev = pos <= -3;
  assign sensors.positioning_done_input = done_cnt == 8'd100;
endmodule : motor_side_model

// *** tb/origin_search_config_logic_bench.sv ***
// Self-checking bench for the origin search controller
`timescale 1ns/1ps
module origin_search_config_logic_bench;
  import origin_search_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, rezero = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, fwd, rev, ecr, busy, irq;
  config_t cfg = '0;
  sensor_t sensors;
  logic signed [15:0] pos;
  logic [32:0] exp_q[$];
  int fails = 0, n_checks = 0, cyc = 0, ecr_n = 0, gap = 0;

  initial forever #20 pclk = ~pclk;

  origin_search_config_logic dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sensors(sensors), .forward_rotation(fwd), .reverse_rotation(rev), .err_counter_reset(ecr),
    .search_busy(busy), .irq(irq));
  motor_side_model m_u (.pclk(pclk), .presetn(presetn), .forward_rotation(fwd), .reverse_rotation(rev),
    .err_counter_reset(ecr), .rezero(rezero), .origin_nc(cfg.origin_nc), .prox_nc(cfg.prox_nc),
    .sensors(sensors), .pos(pos));

  task chk(input logic [32:0] got, input logic [32:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task report_and_stop;
    $display("checks=%0d mismatches=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  // One APB transfer; a read notes its expected error flag and data
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    if (!w) exp_q.push_back(e);
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  // Read results, counter reset timing and the run limit
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 100000) begin
      fails++;
      report_and_stop();
    end else begin
      if (psel && penable && pready && !pwrite) chk({pslverr, prdata}, exp_q.pop_front());
      if (ecr) ecr_n++;
      else if (ecr_n > 0 && busy) gap++;
    end
  end

  // Run one search and check where it stopped and what it reported
  task search(input config_t c, input logic [3:0] ev, input logic signed [15:0] p);
    int i;
    @(posedge pclk);
    cfg <= c;
    apb(1'b1, OFS_CONFIG, {24'h0, c}, 33'h0);
    rezero <= 1'b1;
    @(posedge pclk);
    rezero <= 1'b0;
    ecr_n = 0;
    gap = 0;
    apb(1'b1, OFS_COMMAND, 32'h1, 33'h0);
    @(posedge pclk);
    for (i = 0; i < 40000 && busy !== 1'b0; i++) @(posedge pclk);
    chk(33'(pos), 33'(p));
    chk(33'(ecr_n), c.drive_type == DRIVE_STEPPER ? 33'h0 : 33'(ECR_CYCLES));
    chk(33'(gap > 50), 33'(c.drive_type == DRIVE_SERVO_DONE));
    apb(1'b0, OFS_IRQ_STATUS, 32'h0, {29'h0, ev});
    @(negedge pclk);
    chk(33'(irq), 33'(|ev));
    apb(1'b1, OFS_IRQ_STATUS, 32'hf, 33'h0);
    repeat (2) @(negedge pclk);
    chk(33'(irq), 33'h0);
  endtask : search

  initial begin
    logic [7:0] ofs[7] = '{OFS_CONFIG, OFS_INIT_SPEED, OFS_PROX_SPEED, OFS_HIGH_SPEED, OFS_COMMAND,
      OFS_STATUS, OFS_IRQ_MASK};
    logic [31:0] rv[7] = '{32'h0, 32'h64, 32'h3e8, 32'h2710, 32'h0, 32'h104, 32'h0};
    logic [31:0] spd[4] = '{32'd100, 32'd50000, 32'd50000, 32'd100000};
    logic signed [15:0] stop_at[3] = '{16'sd7, 16'sd4, 16'sd1};
    logic [31:0] r;
    void'($urandom(32'he805));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, unmapped place, write and clamp of speeds
    for (int i = 0; i < 7; i++) apb(1'b0, ofs[i], 32'h0, {1'b0, rv[i]});
    apb(1'b0, 8'h40, 32'h0, {1'b1, 32'h0});
    // Illegal pattern and drive codes keep the old fields, limit mode lands
    apb(1'b1, OFS_CONFIG, 32'h3e, 33'h0);
    apb(1'b0, OFS_CONFIG, 32'h0, 33'h8);
    r = $urandom_range(99999, 1);
    apb(1'b1, OFS_INIT_SPEED, r, 33'h0);
    apb(1'b0, OFS_INIT_SPEED, 32'h0, {1'b0, r});
    apb(1'b1, OFS_HIGH_SPEED, 32'd200000, 33'h0);
    apb(1'b0, OFS_HIGH_SPEED, 32'h0, {16'h0, MAX_PPS});
    $display("test registers done");
    // Equal speeds refuse the search; irq follows the mask
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, OFS_INIT_SPEED, spd[i], 33'h0);
      apb(1'b1, OFS_PROX_SPEED, 32'd50000, 33'h0);
      apb(1'b1, OFS_HIGH_SPEED, spd[i + 2], 33'h0);
      apb(1'b1, OFS_COMMAND, 32'h1, 33'h0);
      apb(1'b0, OFS_IRQ_STATUS, 32'h0, 33'h4);
      @(negedge pclk);
      chk(33'(irq), 33'(i));
      apb(1'b1, OFS_IRQ_MASK, 32'hf, 33'h0);
      @(negedge pclk);
      chk(33'(irq), 33'h1);
      apb(1'b1, OFS_IRQ_STATUS, 32'hf, 33'h0);
    end
    apb(1'b1, OFS_INIT_SPEED, 32'd100, 33'h0);
    // Abort a running fast phase: back to idle with no event
    apb(1'b1, OFS_COMMAND, 32'h1, 33'h0);
    apb(1'b0, OFS_STATUS, 32'h0, 33'h205);
    apb(1'b1, OFS_COMMAND, 32'h2, 33'h0);
    apb(1'b0, OFS_STATUS, 32'h0, 33'h104);
    apb(1'b0, OFS_IRQ_STATUS, 32'h0, 33'h0);
    $display("test abort done");
    $display("test refused done");
    // Each proximity pattern with its own drive type and random polarities
    for (int i = 0; i < 3; i++) begin
      search('{1'($urandom), 1'($urandom), 2'(i), LIMIT_REVERSE, 2'(i), 1'b0}, 4'h1, stop_at[i]);
      $display("test search %0d done", i);
    end
    // Reverse search against the limits in both modes
    search('{1'b0, 1'b0, DRIVE_STEPPER, LIMIT_REVERSE, PROX_UNUSED, 1'b1}, 4'h9, 16'sd7);
    search('{1'b0, 1'b0, DRIVE_STEPPER, LIMIT_STOP_ERR, PROX_UNUSED, 1'b1}, 4'h2, -16'sd3);
    $display("test limits done");
    report_and_stop();
  end
endmodule : origin_search_config_logic_bench
